// File: idq_defs.vh
`ifndef IDQ_DEFS_VH
`define IDQ_DEFS_VH
// ***********************************
// Port offsets
// ***********************************
`define IDQ_OFF_RESULT   4'h4
`define IDQ_OFF_BUFFER   4'h6
`define IDQ_OFF_STATUS   4'h8
`define IDQ_OFF_CLEAR    4'h9
`define IDQ_OFF_TRIG     4'hA
`define IDQ_OFF_IRQSRC   4'hB
`define IDQ_OFF_MODE     4'hC
`define IDQ_OFF_OUTMODE  4'hD
`define IDQ_OFF_DIO      4'hE
// ***********************************
// Field positions
// ***********************************
`define IDQ_EN_FIFO      0
`define IDQ_MODE_DMA     3
`define IDQ_MODE_EXT     2
`define IDQ_MODE_PACER   1
`define IDQ_MODE_SCAN    0
`define IDQ_OM_FIFO      3
`define IDQ_OM_TYPE      2
`define IDQ_OM_FMT       1
`define IDQ_OM_LATCH     0
`define IDQ_ST_IDLE      7
`define IDQ_ST_FULL      6
`define IDQ_ST_HALF      5
`define IDQ_ST_EMPTY     4
`define IDQ_CH_TOP       3
`define IDQ_DAC_LSB      4
`define IDQ_LOW_NIB      4'h0
// ***********************************
// Interrupt source codes
// ***********************************
`define IDQ_IRQ_EOC      2'h0
`define IDQ_IRQ_EXT      2'h1
`define IDQ_IRQ_PACER    2'h2
`define IDQ_IRQ_HALF     2'h3
// ***********************************
// Reset values
// ***********************************
`define IDQ_RST_CH       4'h0
`define IDQ_RST_SEL2     2'h0
`define IDQ_RST_MODE     4'h0
`define IDQ_RST_WORD     16'h0000
`define IDQ_RST_DAC      12'h000
`define IDQ_ZERO_BYTE    8'h00
`endif

// File: idq_regs.v
`timescale 1ns/1ps
`include "idq_defs.vh"

// ***********************************
// Conversion FIFO
// ***********************************
module idq_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 1024,
  parameter AW    = 10
) (
  // Clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             clear,
  // Fill side
  input  wire             s_valid,
  input  wire [WIDTH-1:0] s_data,
  output wire             s_ready,
  // Drain side
  output wire             m_valid,
  output wire [WIDTH-1:0] m_data,
  input  wire             m_ready,
  // Fill level
  output wire [AW:0]      count
);
  // DEPTH must be a power of two so the pointers wrap freely
  localparam [AW:0] FULL_CNT = DEPTH;

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_r;
  reg  [AW-1:0]    rd_ptr_r;
  reg  [AW:0]      count_r;
  wire             push;
  wire             pop;

  assign s_ready = (count_r != FULL_CNT);
  assign m_valid = (count_r != {(AW+1){1'b0}});
  assign push    = s_valid & s_ready;
  assign pop     = m_valid & m_ready;
  assign m_data  = mem[rd_ptr_r];
  assign count   = count_r;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= s_data;
    end
  end

  always @(posedge clk) begin
    if (sys_rst || clear) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      case ({push, pop})
        2'b10:   count_r <= count_r + 1'b1;
        2'b01:   count_r <= count_r - 1'b1;
        default: count_r <= count_r;
      endcase
    end
  end
endmodule // idq_fifo

// ***********************************
// Card control registers
// ***********************************
module idq_regs #(
  parameter RES12      = 1,
  parameter FIFO_DEPTH = 1024,
  parameter FIFO_AW    = 10
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Host I/O port
  input  wire [3:0]  io_addr,
  input  wire        io_rd,
  input  wire        io_wr,
  input  wire [15:0] io_wdata,
  output wire [15:0] io_rdata,
  // Host interrupt and DMA
  input  wire        dma_tc,
  output wire        irq,
  // Converter
  input  wire        adc_eoc_pin,
  input  wire [15:0] adc_data_pin,
  output wire        conv_start,
  output wire [3:0]  mux_chan,
  output wire [3:0]  gain_factor,
  // Trigger sources
  input  wire        ext_trig_pin,
  input  wire        pacer_tick,
  // Jumpers
  input  wire        latch_jumper,
  input  wire        input_type,
  // Output channels
  output wire [11:0] dac1_value,
  output wire [11:0] dac2_value,
  output wire        dac_code_fmt,
  // Digital pins
  input  wire [15:0] input_pins,
  output wire [15:0] output_pins
);
  localparam SW = 36;

  reg  [SW-1:0] sync1_r;
  reg  [SW-1:0] sync2_r;
  reg           eoc_d_r;
  reg           ext_d_r;
  reg           half_d_r;
  reg  [15:0]   rdata_r;
  reg  [15:0]   result_r;
  reg           fifo_on_r;
  reg  [1:0]    gain_sel_r;
  reg  [3:0]    chan_sel_r;
  reg  [1:0]    irq_src_sel_r;
  reg  [3:0]    mode_r;
  reg           dac_latch_sel_r;
  reg           dac_code_fmt_r;
  reg  [11:0]   dac1_in_r;
  reg  [11:0]   dac2_in_r;
  reg  [11:0]   dac1_out_r;
  reg  [11:0]   dac2_out_r;
  reg  [15:0]   output_pins_r;
  reg  [3:0]    scan_ch_r;
  reg  [3:0]    mux_chan_r;
  reg           busy_r;
  reg           conv_start_r;
  reg           irq_r;
  reg           irq_evt;
  reg  [15:0]   rdata_nxt;

  wire          eoc_s;
  wire          ext_s;
  wire [15:0]   adc_s;
  wire          lj_s;
  wire          se_s;
  wire [15:0]   din_s;
  wire          diff;
  wire          eoc_edge;
  wire          ext_edge;
  wire          rd_at;
  wire          wr_at;
  wire [15:0]   adc_word;
  wire [3:0]    stop_ch;
  wire [3:0]    cur_chan;
  wire          soft_trig;
  wire          trig_src;
  wire          stall;
  wire          trig_now;
  wire          transparent;
  wire          fifo_s_ready;
  wire          fifo_m_valid;
  wire [15:0]   fifo_m_data;
  wire          fifo_pop;
  wire [FIFO_AW:0] fifo_count;
  wire          fifo_full;
  wire          fifo_half;
  wire          fifo_empty;
  wire [7:0]    status;

  // ***********************************
  // Pin synchronisers
  // ***********************************
  // Converter data held stable at EOC, so syncing it beside EOC is safe
  always @(posedge clk) begin
    if (sys_rst) begin
      sync1_r <= {SW{1'b0}};
      sync2_r <= {SW{1'b0}};
    end else begin
      sync1_r <= {adc_eoc_pin, ext_trig_pin, adc_data_pin,
                  latch_jumper, input_type, input_pins};
      sync2_r <= sync1_r;
    end
  end

  assign eoc_s = sync2_r[35];
  assign ext_s = sync2_r[34];
  assign adc_s = sync2_r[33:18];
  assign lj_s  = sync2_r[17];
  assign se_s  = sync2_r[16];
  assign din_s = sync2_r[15:0];
  assign diff  = ~se_s;

  always @(posedge clk) begin
    if (sys_rst) begin
      eoc_d_r  <= 1'b0;
      ext_d_r  <= 1'b0;
      half_d_r <= 1'b0;
    end else begin
      eoc_d_r  <= eoc_s;
      ext_d_r  <= ext_s;
      half_d_r <= fifo_half;
    end
  end

  assign eoc_edge = eoc_s & ~eoc_d_r;
  assign ext_edge = ext_s & ~ext_d_r;
  assign rd_at    = io_rd;
  assign wr_at    = io_wr;

  // ***********************************
  // Conversion control
  // ***********************************
  assign adc_word = (RES12 != 0) ?
                    {adc_s[15:4], `IDQ_LOW_NIB} : adc_s;
  assign soft_trig = rd_at && (io_addr == `IDQ_OFF_TRIG) &&
                     !mode_r[`IDQ_MODE_EXT] &&
                     !mode_r[`IDQ_MODE_PACER];
  assign trig_src  = mode_r[`IDQ_MODE_EXT] ? ext_edge :
                     mode_r[`IDQ_MODE_PACER] ? pacer_tick : soft_trig;
  // A full FIFO holds off triggers instead of losing samples
  assign stall     = fifo_on_r & ~fifo_s_ready;
  assign trig_now  = trig_src & ~busy_r & ~stall;

  always @(posedge clk) begin
    if (sys_rst) begin
      busy_r       <= 1'b0;
      conv_start_r <= 1'b0;
      result_r     <= `IDQ_RST_WORD;
    end else begin
      conv_start_r <= trig_now;
      if (trig_now) begin
        busy_r <= 1'b1;
      end else if (eoc_edge) begin
        busy_r <= 1'b0;
      end
      if (eoc_edge) begin
        result_r <= adc_word;
      end
    end
  end

  // ***********************************
  // Channel selection
  // ***********************************
  assign stop_ch = diff ? {1'b0, chan_sel_r[2:0]} : chan_sel_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      scan_ch_r  <= `IDQ_RST_CH;
      mux_chan_r <= `IDQ_RST_CH;
    end else begin
      if (!mode_r[`IDQ_MODE_SCAN]) begin
        scan_ch_r <= `IDQ_RST_CH;
      end else if (eoc_edge) begin
        if (scan_ch_r >= stop_ch) begin
          scan_ch_r <= `IDQ_RST_CH;
        end else begin
          scan_ch_r <= scan_ch_r + 1'b1;
        end
      end
      mux_chan_r <= mode_r[`IDQ_MODE_SCAN] ? scan_ch_r : stop_ch;
    end
  end

  assign cur_chan = {diff | mux_chan_r[`IDQ_CH_TOP],
                     mux_chan_r[2:0]};

  // ***********************************
  // Buffer
  // ***********************************
  assign fifo_pop = rd_at && (io_addr == `IDQ_OFF_BUFFER) &&
                    fifo_on_r;

  idq_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (~fifo_on_r),
    .s_valid (eoc_edge & fifo_on_r),
    .s_data  (adc_word),
    .s_ready (fifo_s_ready),
    .m_valid (fifo_m_valid),
    .m_data  (fifo_m_data),
    .m_ready (fifo_pop),
    .count   (fifo_count)
  );

  assign fifo_full  = ~fifo_s_ready;
  assign fifo_empty = ~fifo_m_valid;
  assign fifo_half  = fifo_count[FIFO_AW] |
                      fifo_count[FIFO_AW-1];

  assign status = {~busy_r, ~fifo_full, ~fifo_half, ~fifo_empty,
                   cur_chan};

  // ***********************************
  // Interrupt
  // ***********************************
  always @* begin
    irq_evt = 1'b0;
    if (mode_r[`IDQ_MODE_DMA]) begin
      irq_evt = dma_tc;
    end else begin
      case (irq_src_sel_r)
        `IDQ_IRQ_EOC:   irq_evt = eoc_edge;
        `IDQ_IRQ_EXT:   irq_evt = ext_edge;
        `IDQ_IRQ_PACER: irq_evt = pacer_tick;
        `IDQ_IRQ_HALF:  irq_evt = fifo_half & ~half_d_r;
        default:        irq_evt = 1'b0;
      endcase
    end
  end

  // New event in the clearing cycle wins over the clear
  always @(posedge clk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else if (irq_evt) begin
      irq_r <= 1'b1;
    end else if (rd_at && (io_addr == `IDQ_OFF_CLEAR)) begin
      irq_r <= 1'b0;
    end
  end

  // ***********************************
  // Register writes
  // ***********************************
  assign transparent = (lj_s == dac_latch_sel_r);

  always @(posedge clk) begin
    if (sys_rst) begin
      fifo_on_r       <= 1'b0;
      gain_sel_r      <= `IDQ_RST_SEL2;
      chan_sel_r      <= `IDQ_RST_CH;
      irq_src_sel_r   <= `IDQ_RST_SEL2;
      mode_r          <= `IDQ_RST_MODE;
      dac_latch_sel_r <= 1'b0;
      dac_code_fmt_r  <= 1'b0;
      dac1_in_r       <= `IDQ_RST_DAC;
      dac2_in_r       <= `IDQ_RST_DAC;
      output_pins_r   <= `IDQ_RST_WORD;
    end else if (wr_at) begin
      case (io_addr)
        `IDQ_OFF_RESULT:  dac1_in_r <= io_wdata[15:`IDQ_DAC_LSB];
        `IDQ_OFF_BUFFER:  dac2_in_r <= io_wdata[15:`IDQ_DAC_LSB];
        `IDQ_OFF_STATUS:  fifo_on_r <= io_wdata[`IDQ_EN_FIFO];
        `IDQ_OFF_CLEAR:   gain_sel_r <= io_wdata[1:0];
        `IDQ_OFF_TRIG:    chan_sel_r <= io_wdata[3:0];
        `IDQ_OFF_IRQSRC:  irq_src_sel_r <= io_wdata[1:0];
        `IDQ_OFF_MODE:    mode_r <= io_wdata[3:0];
        `IDQ_OFF_OUTMODE: begin
          dac_code_fmt_r  <= io_wdata[`IDQ_OM_FMT];
          dac_latch_sel_r <= io_wdata[`IDQ_OM_LATCH];
        end
        `IDQ_OFF_DIO:     output_pins_r <= io_wdata;
        default:          fifo_on_r <= fifo_on_r;
      endcase
    end
  end

  // Buffered mode: a channel-two write moves both latches together
  always @(posedge clk) begin
    if (sys_rst) begin
      dac1_out_r <= `IDQ_RST_DAC;
      dac2_out_r <= `IDQ_RST_DAC;
    end else if (transparent) begin
      dac1_out_r <= dac1_in_r;
      dac2_out_r <= dac2_in_r;
    end else if (wr_at && (io_addr == `IDQ_OFF_BUFFER)) begin
      dac1_out_r <= dac1_in_r;
      dac2_out_r <= io_wdata[15:`IDQ_DAC_LSB];
    end
  end

  // ***********************************
  // Register reads
  // ***********************************
  always @* begin
    rdata_nxt = `IDQ_RST_WORD;
    case (io_addr)
      `IDQ_OFF_RESULT:  rdata_nxt = result_r;
      `IDQ_OFF_BUFFER:  rdata_nxt = (fifo_on_r && fifo_m_valid) ?
                                    fifo_m_data : `IDQ_RST_WORD;
      `IDQ_OFF_STATUS:  rdata_nxt = {`IDQ_ZERO_BYTE, status};
      `IDQ_OFF_IRQSRC:  rdata_nxt = {14'h0000, irq_src_sel_r};
      `IDQ_OFF_MODE:    rdata_nxt = {12'h000, mode_r};
      `IDQ_OFF_OUTMODE: rdata_nxt = {12'h000, fifo_on_r, se_s,
                                     dac_code_fmt_r,
                                     dac_latch_sel_r};
      `IDQ_OFF_DIO:     rdata_nxt = din_s;
      default:          rdata_nxt = `IDQ_RST_WORD;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= `IDQ_RST_WORD;
    end else if (rd_at) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ***********************************
  // Outputs
  // ***********************************
  assign io_rdata     = rdata_r;
  assign irq          = irq_r;
  assign conv_start   = conv_start_r;
  assign mux_chan     = mux_chan_r;
  assign gain_factor  = 4'h1 << gain_sel_r;
  assign dac1_value   = dac1_out_r;
  assign dac2_value   = dac2_out_r;
  assign dac_code_fmt = dac_code_fmt_r;
  assign output_pins  = output_pins_r;
endmodule // idq_regs

// File: idq_regs_assertions.sv
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module idq_regs_chk (
  // Clock and reset
  input wire        clk,
  input wire        sys_rst,
  // Host port
  input wire [3:0]  io_addr,
  input wire        io_rd,
  input wire        io_wr,
  input wire [15:0] io_wdata,
  input wire [15:0] io_rdata,
  input wire        dma_tc,
  input wire        irq,
  // Block outputs
  input wire        conv_start,
  input wire [3:0]  gain_factor,
  input wire        dac_code_fmt,
  input wire [15:0] output_pins
);
  // Shadows of written fields; of these only the gain select cannot be read back
  reg [3:0] md_r;
  reg [1:0] is_r;
  reg [1:0] gs_r;
  reg       fe_r;
  always @(posedge clk) begin
    if (sys_rst) begin
      md_r <= 4'h0;
      is_r <= 2'h0;
      gs_r <= 2'h0;
      fe_r <= 1'b0;
    end else if (io_wr) begin
      if (io_addr == 4'hC) md_r <= io_wdata[3:0];
      if (io_addr == 4'hB) is_r <= io_wdata[1:0];
      if (io_addr == 4'h9) gs_r <= io_wdata[1:0];
      if (io_addr == 4'h8) fe_r <= io_wdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_dma;
    dma_tc && md_r[3];
  endsequence
  sequence s_do;
    io_wr && io_addr == 4'hE;
  endsequence
  AST_IRQ_FALL: assert property (
    $fell(irq) |-> $past(io_rd && io_addr == 4'h9))
    else $error("irq dropped without clear read");
  AST_IRQ_HOLD: assert property (
    irq && !(io_rd && io_addr == 4'h9) |=> irq)
    else $error("irq not held");
  AST_DMA_IRQ: assert property (
    s_dma |=> irq)
    else $error("terminal count gave no irq");
  AST_SOFT_TRIG: assert property (
    conv_start && $past(md_r[2:1]) == 2'b00 |->
      $past(io_rd && io_addr == 4'hA))
    else $error("start without soft trigger read");
  AST_GAIN: assert property (
    gain_factor == (4'h1 << gs_r))
    else $error("gain decode wrong");
  AST_DO: assert property (
    s_do |=> output_pins == $past(io_wdata))
    else $error("output pins wrong");
  AST_FMT: assert property (
    io_wr && io_addr == 4'hD |=> dac_code_fmt == $past(io_wdata[1]))
    else $error("format bit wrong");
  AST_SRC_RB: assert property (
    io_rd && io_addr == 4'hB |=> io_rdata == {14'h0000, is_r})
    else $error("source readback wrong");
  AST_FIFO_OFF: assert property (
    io_rd && io_addr == 4'h6 && !fe_r |=> io_rdata == 16'h0000)
    else $error("buffer port not zero");
  AST_NIB: assert property (
    io_rd && (io_addr == 4'h4 || io_addr == 4'h6) |=> io_rdata[3:0] == 4'h0)
    else $error("low nibble not zero");
endmodule // idq_regs_chk
bind idq_regs idq_regs_chk u_idq_regs_chk (
  .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_rd(io_rd),
  .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .dma_tc(dma_tc), .irq(irq), .conv_start(conv_start),
  .gain_factor(gain_factor), .dac_code_fmt(dac_code_fmt),
  .output_pins(output_pins));

// File: idq_adc_model.sv
`timescale 1ns/1ps
// ****************
// Converter model
// ****************
module idq_adc_model (
  // Clock
  input  wire        clk,
  // Bench control
  input  wire [15:0] sample,
  input  wire [3:0]  dly,
  // Converter pins
  input  wire        conv_start,
  output reg         adc_eoc_pin,
  output reg  [15:0] adc_data_pin
);
  initial begin
    adc_eoc_pin = 1'b0;
    adc_data_pin = 16'h0000;
    forever begin
      @(posedge clk);
      #1;
      if (conv_start === 1'b1) begin
        repeat (dly) @(posedge clk);
        #3 adc_data_pin = sample;
        @(posedge clk);
        #3 adc_eoc_pin = 1'b1;
        // Short hold, so a start right after idle is not missed
        repeat (2) @(posedge clk);
        // Data released after hold: show inverse, not stale value
        #3 adc_eoc_pin = 1'b0;
        adc_data_pin = ~sample;
      end
    end
  end
endmodule // idq_adc_model

// File: isa_daq_control_registers_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
// ****************
// Bench top
// ****************
module isa_daq_control_registers_tb;
  reg         clk = 1'b0, sys_rst = 1'b1, io_rd = 1'b0, io_wr = 1'b0;
  reg         dma_tc = 1'b0, ext_trig_pin = 1'b0, pacer_tick = 1'b0;
  reg         latch_jumper = 1'b0, input_type = 1'b1;
  reg  [3:0]  io_addr = 4'h0, dly = 4'h1;
  reg  [15:0] io_wdata = 16'h0000, input_pins = 16'h0000;
  reg  [15:0] sample = 16'h0000, s, e, m;
  wire [15:0] io_rdata, adc_data_pin, output_pins;
  wire [11:0] dac1_value, dac2_value;
  wire [3:0]  mux_chan, gain_factor;
  wire        irq, adc_eoc_pin, conv_start, dac_code_fmt;
  integer     bad_count = 0, checked = 0, seed = 40, i, n;
  logic [15:0] exp_q[$], msk_q[$], fifo_q[$];
  always #25 clk = ~clk;
  idq_regs #(.RES12(1), .FIFO_DEPTH(16), .FIFO_AW(4)) u_idq_regs (
    .clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .dma_tc(dma_tc), .irq(irq), .adc_eoc_pin(adc_eoc_pin),
    .adc_data_pin(adc_data_pin), .conv_start(conv_start),
    .mux_chan(mux_chan), .gain_factor(gain_factor),
    .ext_trig_pin(ext_trig_pin), .pacer_tick(pacer_tick),
    .latch_jumper(latch_jumper), .input_type(input_type),
    .dac1_value(dac1_value), .dac2_value(dac2_value),
    .dac_code_fmt(dac_code_fmt), .input_pins(input_pins),
    .output_pins(output_pins));
  idq_adc_model u_idq_adc_model (
    .clk(clk), .sample(sample), .dly(dly), .conv_start(conv_start),
    .adc_eoc_pin(adc_eoc_pin), .adc_data_pin(adc_data_pin));
  // Read results land one edge after the strobe
  always @(posedge clk) begin
    if (io_rd === 1'b1 && exp_q.size() > 0) begin
      #1;
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK(io_rdata & m, e & m)
    end
  end
  task close_out;
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task bus(input r, input w, input [3:0] a, input [15:0] d);
    io_rd = r;
    io_wr = w;
    io_addr = a;
    io_wdata = d;
    @(posedge clk);
    #2;
  endtask
  task nop(input integer k);
    repeat (k) bus(1'b0, 1'b0, 4'h0, 16'h0000);
  endtask
  task wr(input [3:0] a, input [15:0] d);
    bus(1'b0, 1'b1, a, d);
  endtask
  task rd(input [3:0] a, input [15:0] x, input [15:0] k);
    exp_q.push_back(x);
    msk_q.push_back(k);
    bus(1'b1, 1'b0, a, 16'h0000);
  endtask
  task wait_idle(output integer c);
    c = 0;
    do begin
      rd(4'h8, 16'h0000, 16'h0000);
      c++;
    end while (io_rdata[7] !== 1'b1 && c < 60);
    if (io_rdata[7] !== 1'b1) begin
      bad_count++;
      close_out;
    end
  endtask
  task conv(input [15:0] v, input go);
    integer c;
    sample = v;
    rd(4'hA, 16'h0000, 16'hFFFF);
    wait_idle(c);
    `CHK(c > 1, go)
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    // Pin synchronisers hold zeros until two edges after reset
    nop(2);
    rd(4'h8, 16'h00E0, 16'h00FF);
    rd(4'h6, 16'h0000, 16'hFFFF);
    rd(4'hD, 16'h0004, 16'h00FF);
    for (i = 0; i < 16; i++) begin
      wr(4'h9, i[15:0]);
      wr(4'hB, i[15:0]);
      rd(4'hB, {14'h0000, i[1:0]}, 16'h00FF);
      wr(4'hC, i[15:0]);
      rd(4'hC, {12'h000, i[3:0]}, 16'h00FF);
      wr(4'hD, i[15:0]);
      rd(4'hD, {12'h000, 2'b01, i[1:0]}, 16'h00FF);
    end
    wr(4'hC, 16'h0000);
    wr(4'hD, 16'h0000);
    input_pins = 16'($random(seed));
    wr(4'hE, ~input_pins);
    nop(2);
    `CHK(output_pins, ~input_pins)
    rd(4'hE, input_pins, 16'hFFFF);
    wr(4'h4, 16'hABCD);
    nop(1);
    `CHK(dac1_value, 12'hABC)
    wr(4'hD, 16'h0001);
    wr(4'h4, 16'h1234);
    nop(1);
    `CHK(dac1_value, 12'hABC)
    wr(4'h6, 16'h5678);
    nop(1);
    `CHK(dac1_value, 12'h123)
    `CHK(dac2_value, 12'h567)
    latch_jumper = 1'b1;
    nop(3);
    wr(4'h4, 16'hFFF0);
    nop(1);
    `CHK(dac1_value, 12'hFFF)
    wr(4'hD, 16'h0000);
    wr(4'hA, 16'h0005);
    s = 16'($random(seed));
    conv(s, 1'b1);
    rd(4'h4, s & 16'hFFF0, 16'hFFFF);
    rd(4'h8, 16'h0085, 16'h008F);
    `CHK(mux_chan, 4'h5)
    wr(4'hC, 16'h0002);
    conv(~s, 1'b0);
    rd(4'h4, s & 16'hFFF0, 16'hFFFF);
    wr(4'hA, 16'h0002);
    wr(4'hC, 16'h0001);
    for (i = 0; i < 4; i++) begin
      conv(16'($random(seed)), 1'b1);
      rd(4'h8, {12'h008, 4'((i + 1) % 3)}, 16'h008F);
    end
    wr(4'hC, 16'h0000);
    rd(4'h9, 16'h0000, 16'hFFFF);
    wr(4'h8, 16'h0001);
    // Slow converter while filling; the last trigger must be refused
    for (i = 0; i < 17; i++) begin
      dly = 4'($random(seed));
      s = 16'($random(seed));
      if (i < 16) fifo_q.push_back(s & 16'hFFF0);
      conv(s, i < 16);
      `CHK(irq, i > 6)
    end
    rd(4'h8, 16'h0090, 16'h00F0);
    wr(4'hC, 16'h0008);
    for (i = 0; i < 16; i++) begin
      rd(4'h6, fifo_q.pop_front(), 16'hFFFF);
    end
    rd(4'h6, 16'h0000, 16'hFFFF);
    rd(4'h8, 16'h00E0, 16'h00F0);
    wr(4'h8, 16'h0000);
    for (i = 0; i < 4; i++) begin
      wait_idle(n);
      rd(4'h9, 16'h0000, 16'hFFFF);
      `CHK(irq, 1'b0)
      wr(4'hB, 16'(i % 3));
      wr(4'hC, 16'h0008 >> i);
      if (i[0] == i[1]) conv(16'($random(seed)), 1'b1);
      `CHK(irq, i == 3)
      {dma_tc, ext_trig_pin, pacer_tick} = 3'b100 >> i;
      nop(1);
      {dma_tc, ext_trig_pin, pacer_tick} = 3'b000;
      for (n = 0; n < 40 && irq !== 1'b1; n++) nop(1);
      `CHK(irq, 1'b1)
    end
    wait_idle(n);
    wr(4'hC, 16'h0000);
    wr(4'hA, 16'h000F);
    input_type = 1'b0;
    nop(3);
    rd(4'h8, 16'h000F, 16'h000F);
    rd(4'hD, 16'h0000, 16'h0004);
    `CHK(mux_chan, 4'h7)
    nop(1);
    close_out;
  end
endmodule // isa_daq_control_registers_tb
